// ### tgtx_pkg.sv
// Package: register offsets, field positions, reset values and timing for the T1 global/transmit bank
package tgtx_pkg;
	localparam logic [9:0] ADDR_CHIP_IDENTITY        = 10'h001;
	localparam logic [9:0] ADDR_SOFT_RESET_TRIGGER   = 10'h004;
	localparam logic [9:0] ADDR_GP_PIN_CONTROL       = 10'h006;
	localparam logic [9:0] ADDR_SECOND_TICK_IRQ_EN   = 10'h00a;
	localparam logic [9:0] ADDR_SECOND_TICK_STATUS   = 10'h00b;
	localparam logic [9:0] ADDR_COUNTER_ACCESS_SEL   = 10'h00e;
	localparam logic [9:0] ADDR_COUNTER_ACCESS_VALUE = 10'h00f;
	localparam logic [9:0] ADDR_BACKPLANE_MUX_CONFIG = 10'h010;
	localparam logic [9:0] ADDR_CARRIER_MODE         = 10'h020;
	localparam logic [9:0] ADDR_TX_DEJITTER_CONFIG   = 10'h021;
	localparam logic [9:0] ADDR_TX_PATH_CONFIG       = 10'h022;
	localparam logic [9:0] ADDR_TX_DRIVER_CONFIG     = 10'h023;
	localparam logic [9:0] ADDR_FILL_LEVEL_MONITOR   = 10'h038;

	// Field positions
	localparam int BIT_PIN_DIRECTION    = 0;
	localparam int BIT_PIN_LEVEL        = 2;
	localparam int BIT_TICK             = 0;
	localparam int BIT_TX_MUX           = 0;
	localparam int BIT_RX_MUX           = 3;
	localparam int BIT_CARRIER_FAMILY   = 0;
	localparam int BIT_DJ_BANDWIDTH     = 0;
	localparam int BIT_DJ_DEPTH_LO      = 1;
	localparam int BIT_DJ_ENABLE        = 3;
	localparam int BIT_DJ_WIDEN         = 4;
	localparam int BIT_DJ_PEAK_SEL      = 5;
	localparam int BIT_TX_LINE_CODE     = 0;
	localparam int BIT_TX_POWER_DOWN    = 4;
	localparam int BIT_DRIVER_TRISTATE  = 4;

	// Writable masks; reserved bits read zero
	localparam logic [7:0] MASK_GP_PIN    = 8'h05;
	localparam logic [7:0] MASK_BIT0      = 8'h01;
	localparam logic [7:0] MASK_SEL       = 8'h0f;
	localparam logic [7:0] MASK_MUX       = 8'h09;
	localparam logic [7:0] MASK_DEJITTER  = 8'h3f;
	localparam logic [7:0] MASK_TX_PATH   = 8'h11;
	localparam logic [7:0] MASK_TX_DRIVER = 8'h1f;

	// Reset values
	localparam logic [7:0] RST_GP_PIN    = 8'h01;
	localparam logic [7:0] RST_TX_DRIVER = 8'h10;
	localparam logic [7:0] RST_ZERO      = 8'h00;

	localparam logic [3:0] COUNTER_SEL_LAST = 4'h b;

	// Depth codes
	localparam logic [1:0] DEPTH_128 = 2'b00;
	localparam logic [1:0] DEPTH_64  = 2'b01;
	localparam logic [6:0] DEPTH_128_BITS = 7'h7f;
	localparam logic [6:0] DEPTH_64_BITS  = 7'h40;
	localparam logic [6:0] DEPTH_32_BITS  = 7'h20;
	localparam logic [6:0] WIDEN_128 = 7'h04;
	localparam logic [6:0] WIDEN_64  = 7'h03;
	localparam logic [6:0] WIDEN_32  = 7'h02;

	// One-second timer
	localparam int  CLK_HZ       = 25_000_000;
	localparam int  TICK_SECONDS = 1;
	localparam int  TICK_CYCLES  = CLK_HZ * TICK_SECONDS;
endpackage

// ### tgtx_regs.sv
// T1/J1 global and transmit control register bank
//
// Functional notes
// - Identity register is read-only; high nibble part code, low nibble revision.
// - Any write to the soft reset register resets the device.
// - Soft reset works only with the oscillator clock running.
// - Soft reset restores all registers except carrier mode register.
// - Pin direction 0 output, 1 input; default input.
// - Pin level drives pin when output; reads sampled pin when input.
// - Free-running one-second timer sets tick flag each second.
// - Writing 1 clears tick flag; writing 0 leaves it.
// - Interrupt asserted only when tick enable and tick flag both set.
// - Four-bit select chooses counter registers 00h through 0Bh.
// - Access data register presents selected counter byte, read-only.
// - Receive and transmit mux bits: 0 non-multiplexed, 1 multiplexed.
// - Monitor mode 0 writes current pointer distance into fill monitor.
// - Monitor mode 1 keeps peak pointer distance.
// - Widen bit widens bandwidth within 2/3/4 bits of FIFO edges.
// - Dejitter enable 1 active, 0 bypassed; default disabled.
// - Depth 00 128 bits, 01 64 bits, 1x 32 bits.
// - Bandwidth bit 0 selects 5 Hz, 1 selects 1.26 Hz.
// - Transmit power-down powers path down and tristates driver.
// - Line code 0 B8ZS, 1 AMI.
// - Driver tristate 1 floats driver only; default 1.
// - Carrier family bit 0 E1, 1 T1/J1.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tgtx_regs #(
	parameter logic [3:0] PART_CODE     = 4'h a,     // Arbitrary value
	parameter logic [3:0] REVISION_CODE = 4'h 3,     // Arbitrary value
	parameter int         TICK_PERIOD   = tgtx_pkg::TICK_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [9:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        gp_pin_in,
	output logic             gp_pin_out,
	output logic             gp_pin_oe,
	output logic             irq_out,
	output logic      [3:0]  counter_sel,
	input  wire logic [7:0]  counter_data,
	input  wire logic [6:0]  fifo_distance,
	output logic             rx_sys_muxed,
	output logic             tx_sys_muxed,
	output logic             carrier_family_sel,
	output logic             tx_dejitter_enable,
	output logic [1:0]       dejitter_depth,
	output logic             dejitter_bandwidth,
	output logic             dejitter_widened,
	output logic             tx_power_down,
	output logic             tx_line_code_sel,
	output logic             driver_tristate,
	output logic             line_driver_hiz,
	output logic [3:0]       pulse_shape_sel,
	output logic             soft_reset_pulse
);
	import tgtx_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
		hit = (a == target);
	endfunction

	function automatic logic [6:0] depth_bits(input logic [1:0] d);
		case (d)
			DEPTH_128: depth_bits = DEPTH_128_BITS;
			DEPTH_64:  depth_bits = DEPTH_64_BITS;
			default:   depth_bits = DEPTH_32_BITS;
		endcase
	endfunction

	function automatic logic [6:0] widen_window(input logic [1:0] d);
		case (d)
			DEPTH_128: widen_window = WIDEN_128;
			DEPTH_64:  widen_window = WIDEN_64;
			default:   widen_window = WIDEN_32;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	logic gp_sync1_reg;
	logic gp_sync2_reg;
	logic gp_sync1_next;
	logic gp_sync2_next;

	always_comb begin
		gp_sync1_next = gp_pin_in;
		gp_sync2_next = gp_sync1_reg;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gp_sync1_reg <= 1'b0;
			gp_sync2_reg <= 1'b0;
		end else begin
			gp_sync1_reg <= gp_sync1_next;
			gp_sync2_reg <= gp_sync2_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0]  gp_pin_reg,    gp_pin_next;
	logic        tick_en_reg,   tick_en_next;
	logic        tick_flag_reg, tick_flag_next;
	logic [3:0]  sel_reg,       sel_next;
	logic [7:0]  mux_reg,       mux_next;
	logic [7:0]  mode_reg,      mode_next;
	logic [7:0]  dj_reg,        dj_next;
	logic [7:0]  txp_reg,       txp_next;
	logic [7:0]  txd_reg,       txd_next;
	logic [6:0]  fill_reg,      fill_next;
	logic [31:0] tick_cnt_reg,  tick_cnt_next;
	logic        srst_reg,      srst_next;
	logic [7:0]  rdata_reg,     rdata_next;
	logic        tick_done;
	logic        soft_rst;

	// Soft reset only acts on sys_clk edges, so a stopped oscillator means no reset
	assign soft_rst  = srst_reg;
	assign tick_done = (tick_cnt_reg == 32'(TICK_PERIOD - 1));

	always_comb begin
		gp_pin_next    = gp_pin_reg;
		tick_en_next   = tick_en_reg;
		tick_flag_next = tick_flag_reg;
		sel_next       = sel_reg;
		mux_next       = mux_reg;
		mode_next      = mode_reg;
		dj_next        = dj_reg;
		txp_next       = txp_reg;
		txd_next       = txd_reg;
		fill_next      = fill_reg;
		srst_next      = 1'b0;
		tick_cnt_next  = tick_done ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;

		if (reg_wr) begin
			if (hit(reg_addr, ADDR_SOFT_RESET_TRIGGER))
				srst_next = 1'b1;
			if (hit(reg_addr, ADDR_GP_PIN_CONTROL))
				gp_pin_next = reg_wdata & MASK_GP_PIN;
			if (hit(reg_addr, ADDR_SECOND_TICK_IRQ_EN))
				tick_en_next = reg_wdata[BIT_TICK];
			if (hit(reg_addr, ADDR_SECOND_TICK_STATUS) && reg_wdata[BIT_TICK])
				tick_flag_next = 1'b0;
			if (hit(reg_addr, ADDR_COUNTER_ACCESS_SEL))
				sel_next = reg_wdata[3:0];
			if (hit(reg_addr, ADDR_BACKPLANE_MUX_CONFIG))
				mux_next = reg_wdata & MASK_MUX;
			if (hit(reg_addr, ADDR_CARRIER_MODE))
				mode_next = reg_wdata & MASK_SEL;
			if (hit(reg_addr, ADDR_TX_DEJITTER_CONFIG))
				dj_next = reg_wdata & MASK_DEJITTER;
			if (hit(reg_addr, ADDR_TX_PATH_CONFIG))
				txp_next = reg_wdata & MASK_TX_PATH;
			if (hit(reg_addr, ADDR_TX_DRIVER_CONFIG))
				txd_next = reg_wdata & MASK_TX_DRIVER;
		end
		// Set beats a simultaneous clear
		if (tick_done)
			tick_flag_next = 1'b1;

		if (!dj_reg[BIT_DJ_PEAK_SEL])
			fill_next = fifo_distance;
		else if (fifo_distance > fill_reg)
			fill_next = fifo_distance;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_reg <= RST_ZERO;
		end else begin
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n || soft_rst) begin
			gp_pin_reg    <= RST_GP_PIN;
			tick_en_reg   <= 1'b0;
			tick_flag_reg <= 1'b0;
			sel_reg       <= 4'h0;
			mux_reg       <= RST_ZERO;
			dj_reg        <= RST_ZERO;
			txp_reg       <= RST_ZERO;
			txd_reg       <= RST_TX_DRIVER;
			fill_reg      <= 7'h00;
			tick_cnt_reg  <= 32'h0000_0000;
		end else begin
			gp_pin_reg    <= gp_pin_next;
			tick_en_reg   <= tick_en_next;
			tick_flag_reg <= tick_flag_next;
			sel_reg       <= sel_next;
			mux_reg       <= mux_next;
			dj_reg        <= dj_next;
			txp_reg       <= txp_next;
			txd_reg       <= txd_next;
			fill_reg      <= fill_next;
			tick_cnt_reg  <= tick_cnt_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			srst_reg <= 1'b0;
		end else begin
			srst_reg <= srst_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path, data valid the cycle after the strobe
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_CHIP_IDENTITY:        rdata_next = {PART_CODE, REVISION_CODE};
				ADDR_GP_PIN_CONTROL: begin
					rdata_next = gp_pin_reg;
					if (gp_pin_reg[BIT_PIN_DIRECTION])
						rdata_next[BIT_PIN_LEVEL] = gp_sync2_reg;
				end
				ADDR_SECOND_TICK_IRQ_EN:   rdata_next = {7'h00, tick_en_reg};
				ADDR_SECOND_TICK_STATUS:   rdata_next = {7'h00, tick_flag_reg};
				ADDR_COUNTER_ACCESS_SEL:   rdata_next = {4'h0, sel_reg};
				// Selects above 0Bh return zero rather than alias a counter
				ADDR_COUNTER_ACCESS_VALUE: rdata_next = (sel_reg <= COUNTER_SEL_LAST) ? counter_data : 8'h00;
				ADDR_BACKPLANE_MUX_CONFIG: rdata_next = mux_reg;
				ADDR_CARRIER_MODE:         rdata_next = mode_reg;
				ADDR_TX_DEJITTER_CONFIG:   rdata_next = dj_reg;
				ADDR_TX_PATH_CONFIG:       rdata_next = txp_reg;
				ADDR_TX_DRIVER_CONFIG:     rdata_next = txd_reg;
				ADDR_FILL_LEVEL_MONITOR:   rdata_next = {1'b0, fill_reg};
				default:                   rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata          = rdata_reg;
	assign gp_pin_oe          = !gp_pin_reg[BIT_PIN_DIRECTION];
	assign gp_pin_out         = gp_pin_reg[BIT_PIN_LEVEL];
	assign irq_out            = tick_en_reg & tick_flag_reg;
	assign counter_sel        = sel_reg;
	assign rx_sys_muxed       = mux_reg[BIT_RX_MUX];
	assign tx_sys_muxed       = mux_reg[BIT_TX_MUX];
	assign carrier_family_sel = mode_reg[BIT_CARRIER_FAMILY];
	assign tx_dejitter_enable = dj_reg[BIT_DJ_ENABLE];
	assign dejitter_depth     = dj_reg[BIT_DJ_DEPTH_LO +: 2];
	assign dejitter_bandwidth = dj_reg[BIT_DJ_BANDWIDTH];
	// Widened while distance is near empty or near full for the chosen depth
	assign dejitter_widened   = dj_reg[BIT_DJ_ENABLE] & dj_reg[BIT_DJ_WIDEN] &
		((fifo_distance < widen_window(dejitter_depth)) ||
		 (fifo_distance > (depth_bits(dejitter_depth) - widen_window(dejitter_depth))));
	assign tx_power_down      = txp_reg[BIT_TX_POWER_DOWN];
	assign tx_line_code_sel   = txp_reg[BIT_TX_LINE_CODE];
	assign driver_tristate    = txd_reg[BIT_DRIVER_TRISTATE];
	assign line_driver_hiz    = txd_reg[BIT_DRIVER_TRISTATE] | txp_reg[BIT_TX_POWER_DOWN];
	assign pulse_shape_sel    = txd_reg[3:0];
	assign soft_reset_pulse   = srst_reg;
endmodule
`default_nettype wire

// ### tgtx_properties.sv
// Assertion checker for the T1 global and transmit register bank
`timescale 1ns/10ps
`default_nettype none
module tgtx_properties #(
	parameter logic [3:0] PART_CODE     = 4'h0,
	parameter logic [3:0] REVISION_CODE = 4'h0,
	parameter int         TICK_PERIOD   = 20
) (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       gp_pin_out,
	input wire logic       gp_pin_oe,
	input wire logic       irq_out,
	input wire logic [3:0] counter_sel,
	input wire logic [7:0] counter_data,
	input wire logic       tx_power_down,
	input wire logic       driver_tristate,
	input wire logic       line_driver_hiz,
	input wire logic       soft_reset_pulse
);
	import tgtx_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Mirror of the second count; soft reset restarts it
	int tick_cnt_reg;
	int tick_cnt_next;
	always_comb tick_cnt_next = (!rst_n || soft_reset_pulse || tick_cnt_reg == TICK_PERIOD - 1) ? 0 : tick_cnt_reg + 1;
	always_ff @(posedge sys_clk) tick_cnt_reg <= tick_cnt_next;
	sequence s_srst_wr; reg_wr && reg_addr == ADDR_SOFT_RESET_TRIGGER && !soft_reset_pulse; endsequence
	sequence s_pulse; soft_reset_pulse ##1 !soft_reset_pulse; endsequence
	property p_identity; reg_rd && reg_addr == ADDR_CHIP_IDENTITY |=> reg_rdata == {PART_CODE, REVISION_CODE}; endproperty
	a_identity: assert property (p_identity) else $error("identity read wrong");
	property p_srst; s_srst_wr |=> s_pulse; endproperty
	a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
	property p_srst_def; soft_reset_pulse |=> driver_tristate && !tx_power_down && !gp_pin_oe && !irq_out; endproperty
	a_srst_def: assert property (p_srst_def) else $error("soft reset defaults wrong");
	property p_irq_off; reg_wr && reg_addr == ADDR_SECOND_TICK_IRQ_EN && !reg_wdata[0] |=> !irq_out; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
	property p_tick; $rose(irq_out) && !$past(reg_wr) |-> tick_cnt_reg == 0; endproperty
	a_tick: assert property (p_tick) else $error("tick out of phase");
	property p_gp_out;
		gp_pin_oe && reg_wr && reg_addr == ADDR_GP_PIN_CONTROL && !reg_wdata[0] && !soft_reset_pulse
			|=> gp_pin_oe && gp_pin_out == $past(reg_wdata[2]);
	endproperty
	a_gp_out: assert property (p_gp_out) else $error("pin drive wrong");
	property p_cnt;
		reg_rd && reg_addr == ADDR_COUNTER_ACCESS_VALUE && counter_sel <= COUNTER_SEL_LAST && !soft_reset_pulse
			|=> reg_rdata == $past(counter_data);
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter data wrong");
	property p_hiz; line_driver_hiz == (driver_tristate || tx_power_down); endproperty
	a_hiz: assert property (p_hiz) else $error("driver float wrong");
endmodule
`default_nettype wire

// ### tgtx_host.sv
// Host model driving the register bus
`timescale 1ns/10ps
`default_nettype none
module tgtx_host (
	input  wire logic       sys_clk,
	output logic      [9:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	import tgtx_pkg::*;
	initial begin
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	////////////////////////////////////////
	// Idle cycle after each write keeps strobe edges apart
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
	// Only issued while the oscillator runs
	task automatic set_mode(input logic [7:0] d);
		wr(ADDR_CARRIER_MODE, d);
		wr(ADDR_SOFT_RESET_TRIGGER, 8'ha5);
	endtask
endmodule
`default_nettype wire

// ### tgtx_regs_tb.sv
// Self-checking bench for the T1 global and transmit register bank
`timescale 1ns/10ps
`default_nettype none
module tgtx_regs_tb;
	import tgtx_pkg::*;
	localparam int         TICK = 20;
	localparam logic [3:0] PART = 4'h6; // Arbitrary
	localparam logic [3:0] REV  = 4'h2; // Arbitrary
	logic            sys_clk, rst_n, pin_drv;
	logic      [6:0] fifo_distance;
	wire logic [9:0] reg_addr;
	wire logic [7:0] reg_wdata, reg_rdata, counter_data;
	wire logic [3:0] counter_sel, pulse_shape_sel;
	wire logic [1:0] dejitter_depth;
	wire logic       reg_wr, reg_rd, gp_pin_in, gp_pin_out, gp_pin_oe, irq_out, rx_sys_muxed, tx_sys_muxed;
	wire logic       carrier_family_sel, tx_dejitter_enable, dejitter_bandwidth, dejitter_widened;
	wire logic       tx_power_down, tx_line_code_sel, driver_tristate, line_driver_hiz, soft_reset_pulse;
	int              errors = 0;
	int              tests_run = 0;
	assign gp_pin_in = gp_pin_oe ? gp_pin_out : pin_drv;
	assign counter_data = {counter_sel, ~counter_sel};
	tgtx_regs #(.PART_CODE(PART), .REVISION_CODE(REV), .TICK_PERIOD(TICK)) u_tgtx_regs (.*);
	tgtx_host u_tgtx_host (.*);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_tgtx_host.rd(a, d);
		chk($sformatf("reg %h", a), exp, d);
	endtask
	task automatic t_defaults();
		rchk(ADDR_CHIP_IDENTITY, {PART, REV});
		rchk(ADDR_GP_PIN_CONTROL, RST_GP_PIN);
		rchk(ADDR_TX_DRIVER_CONFIG, RST_TX_DRIVER);
		rchk(ADDR_TX_DEJITTER_CONFIG, RST_ZERO);
		rchk(10'h3ff, RST_ZERO);
		u_tgtx_host.wr(ADDR_CHIP_IDENTITY, 8'h00);
		rchk(ADDR_CHIP_IDENTITY, {PART, REV});
	endtask
	task automatic t_fields();
		logic [9:0] a [5] = '{ADDR_COUNTER_ACCESS_SEL, ADDR_BACKPLANE_MUX_CONFIG, ADDR_TX_DEJITTER_CONFIG,
			ADDR_TX_PATH_CONFIG, ADDR_TX_DRIVER_CONFIG};
		logic [7:0] m [5] = '{MASK_SEL, MASK_MUX, MASK_DEJITTER, MASK_TX_PATH, MASK_TX_DRIVER};
		for (int i = 0; i < 5; i++) begin
			u_tgtx_host.wr(a[i], 8'hff);
			rchk(a[i], m[i]);
		end
		chk("mux", 8'h03, {6'h00, rx_sys_muxed, tx_sys_muxed});
		chk("dj", 8'h0f, {4'h0, tx_dejitter_enable, dejitter_depth, dejitter_bandwidth});
		chk("tx", 8'h07, {5'h00, tx_power_down, tx_line_code_sel, line_driver_hiz});
		chk("drv", 8'h1f, {3'h0, driver_tristate, pulse_shape_sel});
		u_tgtx_host.wr(ADDR_BACKPLANE_MUX_CONFIG, 8'h08);
		u_tgtx_host.wr(ADDR_TX_PATH_CONFIG, 8'h01);
		u_tgtx_host.wr(ADDR_TX_DRIVER_CONFIG, 8'h00);
		chk("mux", 8'h02, {6'h00, rx_sys_muxed, tx_sys_muxed});
		chk("tx", 8'h02, {5'h00, tx_power_down, tx_line_code_sel, line_driver_hiz});
		chk("drv", 8'h00, {3'h0, driver_tristate, pulse_shape_sel});
		// Power-down alone must float the driver while the tristate bit stays clear
		u_tgtx_host.wr(ADDR_TX_PATH_CONFIG, 8'h10);
		chk("tx", 8'h05, {5'h00, tx_power_down, tx_line_code_sel, line_driver_hiz});
		chk("drv", 8'h00, {3'h0, driver_tristate, pulse_shape_sel});
	endtask
	task automatic t_srst();
		u_tgtx_host.set_mode(8'h05);
		rchk(ADDR_CARRIER_MODE, 8'h05);
		rchk(ADDR_BACKPLANE_MUX_CONFIG, RST_ZERO);
		rchk(ADDR_TX_DRIVER_CONFIG, RST_TX_DRIVER);
		chk("family", 8'h01, {7'h00, carrier_family_sel});
	endtask
	task automatic t_gpio();
		u_tgtx_host.wr(ADDR_GP_PIN_CONTROL, 8'h00);
		u_tgtx_host.wr(ADDR_GP_PIN_CONTROL, 8'h04);
		chk("pin", 8'h03, {6'h00, gp_pin_oe, gp_pin_out});
		rchk(ADDR_GP_PIN_CONTROL, 8'h04);
		u_tgtx_host.wr(ADDR_GP_PIN_CONTROL, 8'h05);
		repeat (3) @(posedge sys_clk);
		rchk(ADDR_GP_PIN_CONTROL, 8'h01);
		pin_drv <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk(ADDR_GP_PIN_CONTROL, 8'h05);
	endtask
	task automatic t_counter();
		for (int s = 0; s <= 12; s++) begin
			u_tgtx_host.wr(ADDR_COUNTER_ACCESS_SEL, 8'(s));
			chk("sel", 8'(s), {4'h0, counter_sel});
			rchk(ADDR_COUNTER_ACCESS_VALUE, s < 12 ? {4'(s), ~4'(s)} : 8'h00);
		end
	endtask
	task automatic t_fill();
		logic [15:0] v [10] = '{16'h1c03, 16'h1c20, 16'h1c3f, 16'h1e3f, 16'h18f9, 16'h18f6, 16'h1a7d, 16'h1a7a,
			16'h1402, 16'h0c02};
		u_tgtx_host.wr(ADDR_TX_DEJITTER_CONFIG, 8'h00);
		fifo_distance <= 7'h30;
		@(posedge sys_clk);
		rchk(ADDR_FILL_LEVEL_MONITOR, 8'h30);
		u_tgtx_host.wr(ADDR_TX_DEJITTER_CONFIG, 8'h20);
		fifo_distance <= 7'h50;
		@(posedge sys_clk);
		fifo_distance <= 7'h10;
		rchk(ADDR_FILL_LEVEL_MONITOR, 8'h50);
		for (int i = 0; i < 10; i++) begin
			u_tgtx_host.wr(ADDR_TX_DEJITTER_CONFIG, v[i][15:8]);
			fifo_distance <= v[i][7:1];
			@(posedge sys_clk);
			chk("widen", {7'h00, v[i][0]}, {7'h00, dejitter_widened});
		end
	endtask
	task automatic wait_irq(output int n);
		n = 0;
		while (irq_out !== 1'b1 && n < 2 * TICK) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task automatic t_tick();
		int n;
		u_tgtx_host.wr(ADDR_SECOND_TICK_IRQ_EN, 8'h01);
		u_tgtx_host.wr(ADDR_SECOND_TICK_STATUS, 8'h01);
		wait_irq(n);
		rchk(ADDR_SECOND_TICK_STATUS, 8'h01);
		u_tgtx_host.wr(ADDR_SECOND_TICK_STATUS, 8'h00);
		rchk(ADDR_SECOND_TICK_STATUS, 8'h01);
		u_tgtx_host.wr(ADDR_SECOND_TICK_STATUS, 8'h01);
		chk("irq", 8'h00, {7'h00, irq_out});
		rchk(ADDR_SECOND_TICK_STATUS, 8'h00);
		wait_irq(n);
		chk("period", 8'(TICK), 8'(n + 10));
		u_tgtx_host.wr(ADDR_SECOND_TICK_IRQ_EN, 8'h00);
		// Clear first so the flag read below proves a fresh tick with the enable off
		u_tgtx_host.wr(ADDR_SECOND_TICK_STATUS, 8'h01);
		repeat (TICK) @(posedge sys_clk);
		chk("irq", 8'h00, {7'h00, irq_out});
		rchk(ADDR_SECOND_TICK_STATUS, 8'h01);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		close_out();
	end
	initial begin
		rst_n = 1'b0;
		pin_drv = 1'b0;
		fifo_distance = 7'h00;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_defaults();
		t_fields();
		t_srst();
		t_gpio();
		t_counter();
		t_fill();
		t_tick();
		close_out();
	end
endmodule
bind tgtx_regs tgtx_properties #(.PART_CODE(PART_CODE), .REVISION_CODE(REVISION_CODE), .TICK_PERIOD(TICK_PERIOD))
	u_tgtx_properties (.*);
`default_nettype wire
